//--- inc/svm_pkg.sv
/*
 * svm_pkg: constants, register map and carrier types for the space
 * vector modulator.
 * assumes: 4.12 signed fixed point on the voltage references and one
 * compare count per pwm clock count.
 */
package svm_pkg;

    // fixed point formats
    localparam int REF_W = 16;              // 4.12 signed reference width
    localparam int FRAC_W = 12;             // fraction bits of 4.12
    localparam int TIME_W = 18;             // signed boundary time width
    localparam int CMP_W = 16;              // phase compare width
    localparam int DIV_W = 28;              // divider operand width

    // dc bus voltage, per unit, 4.12
    localparam logic signed [REF_W-1:0] BUS_VOLTAGE_PU = 16'sh1B8D;
    // pwm period in counts
    localparam logic [CMP_W-1:0] PWM_PERIOD_COUNT = 16'h03E8;
    // period over per unit bus voltage
    localparam logic signed [REF_W-1:0] BUS_INVERSE_SCALE = 16'sh0245;
    // sqrt3, sqrt3/2 and 3/2 in 4.12
    localparam logic signed [REF_W-1:0] SQRT3_Q12 = 16'sh1BB6;
    localparam logic signed [REF_W-1:0] HALF_SQRT3_Q12 = 16'sh0DDB;
    localparam logic signed [REF_W-1:0] THREE_HALF_Q12 = 16'sh1800;
    // scaled products carry two 4.12 fractions
    localparam int PROD_SHIFT = 24;
    localparam logic [CMP_W-1:0] HALF_PERIOD = 16'h01F4;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ALPHA = 8'h04;
    localparam logic [7:0] REG_BETA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_CMP12 = 8'h10;
    localparam logic [7:0] REG_CMP3 = 8'h14;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_SECTOR_LSB = 0;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_SAT_BIT = 5;
    localparam int ST_ZERO_BIT = 6;
    localparam int CMP_HI_LSB = 16;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // three phase compares presented together
    typedef struct packed {
        logic [CMP_W-1:0] phase_one_compare;
        logic [CMP_W-1:0] phase_two_compare;
        logic [CMP_W-1:0] phase_three_compare;
    } svm_compare_s;

    // three on times
    typedef struct packed {
        logic [CMP_W-1:0] first;
        logic [CMP_W-1:0] second;
        logic [CMP_W-1:0] third;
    } svm_ontime_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SELECT = 3'b001,
        ST_DIVIDE = 3'b010,
        ST_ONTIME = 3'b011,
        ST_LOAD = 3'b100
    } svm_state_e;

endpackage

//--- hw/svm_divider.sv
/*
 * svm_divider: unsigned restoring divider, one quotient bit per clock.
 * assumes: start is a one cycle pulse while not busy; den is nonzero.
 */
`timescale 1ns/1ns
module svm_divider #(
    parameter int W = 28
) (
    input wire logic clock,           // system clock
    input wire logic rst_n,           // async reset, active low
    input wire logic start,           // pulse, latches operands
    input wire logic [W-1:0] num,     // dividend
    input wire logic [W-1:0] den,     // divisor
    output logic done,                // pulse, quotient valid
    output logic [W-1:0] quot         // quotient
);
    logic [W-1:0] rem_ff;
    logic [W-1:0] den_ff;
    logic [5:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [W-1:0] quo_ff;
    logic [W-1:0] shifted;

    // partial remainder with next dividend bit
    assign shifted = {rem_ff[W-2:0], quo_ff[W-1]};

    // iteration registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rem_ff <= '0;
            den_ff <= '0;
            quo_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start) begin
                rem_ff <= '0;
                den_ff <= den;
                quo_ff <= num;
                cnt_ff <= 6'(W);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (shifted >= den_ff) begin
                    rem_ff <= shifted - den_ff;
                    quo_ff <= {quo_ff[W-2:0], 1'b1};
                end else begin
                    rem_ff <= shifted;
                    quo_ff <= {quo_ff[W-2:0], 1'b0};
                end
                cnt_ff <= cnt_ff - 6'h01;
                if (cnt_ff == 6'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign done = done_ff;
    assign quot = quo_ff;
endmodule

//--- hw/svm_top.sv
/*
 * svm_top: space vector modulator with an axi4-lite register slave.
 * takes alpha and beta voltage references, finds the sector, computes
 * and saturates the boundary times and loads three phase compares.
 * assumes: period_tick pulses once per pwm period from the pwm unit,
 * and the pwm unit takes compare_out when compare_load pulses.
 */
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module svm_top (
    input wire logic clock,                    // 125 mhz system clock
    input wire logic rst_n,                    // async reset, active low
    input wire logic period_tick,              // pwm period boundary pulse
    output svm_pkg::svm_compare_s compare_out, // phase compares, registered
    output logic compare_load,                 // pulse, new compares valid
    input wire logic [7:0] s_axi_awaddr,       // write address
    input wire logic s_axi_awvalid,            // write address valid
    output logic s_axi_awready,                // write address ready
    input wire logic [31:0] s_axi_wdata,       // write data
    input wire logic [3:0] s_axi_wstrb,        // write byte strobes
    input wire logic s_axi_wvalid,             // write data valid
    output logic s_axi_wready,                 // write data ready
    output logic [1:0] s_axi_bresp,            // write response
    output logic s_axi_bvalid,                 // write response valid
    input wire logic s_axi_bready,             // write response ready
    input wire logic [7:0] s_axi_araddr,       // read address
    input wire logic s_axi_arvalid,            // read address valid
    output logic s_axi_arready,                // read address ready
    output logic [31:0] s_axi_rdata,           // read data
    output logic [1:0] s_axi_rresp,            // read response
    output logic s_axi_rvalid,                 // read data valid
    input wire logic s_axi_rready              // read data ready
);
    import svm_pkg::*;

    // register file
    logic enable_ff;
    logic signed [REF_W-1:0] alpha_ff;
    logic signed [REF_W-1:0] beta_ff;
    // axi state
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_write;
    // datapath
    svm_state_e state_ff;
    logic signed [REF_W:0] ref1_ff;
    logic signed [REF_W:0] ref2_ff;
    logic signed [REF_W:0] ref3_ff;
    logic signed [TIME_W-1:0] x_ff;
    logic signed [TIME_W-1:0] y_ff;
    logic signed [TIME_W-1:0] z_ff;
    logic [2:0] sector_ff;
    logic [TIME_W-1:0] t1_ff;
    logic [TIME_W-1:0] t2_ff;
    logic sat_ff;
    svm_ontime_s on_ff;
    svm_compare_s compare_ff;
    logic compare_load_ff;
    // combinational helpers
    logic signed [47:0] k_alpha;
    logic signed [47:0] k_beta;
    logic signed [47:0] x_full;
    logic signed [47:0] y_full;
    logic signed [47:0] z_full;
    logic signed [47:0] r2_full;
    logic signed [TIME_W-1:0] t1_raw;
    logic signed [TIME_W-1:0] t2_raw;
    logic [TIME_W-1:0] t1_pos;
    logic [TIME_W-1:0] t2_pos;
    logic [TIME_W-1:0] t_sum;
    logic [2:0] sector;
    logic [TIME_W-1:0] t_rest;
    logic [TIME_W-1:0] ta;
    logic [DIV_W-1:0] den;
    logic [DIV_W-1:0] num1;
    logic [DIV_W-1:0] num2;
    logic [DIV_W-1:0] q1;
    logic [DIV_W-1:0] q2;
    logic div_start;
    logic div_done;
    logic [31:0] rd_word;
    logic rd_ok;

    // scaled references with period over bus voltage
    assign k_alpha = 48'(BUS_INVERSE_SCALE) * 48'(alpha_ff);
    assign k_beta = 48'(BUS_INVERSE_SCALE) * 48'(beta_ff);
    // X, Y, Z in counts with two fractions
    assign x_full = 48'(SQRT3_Q12) * k_beta;
    assign y_full = 48'(HALF_SQRT3_Q12) * k_beta
        + 48'(THREE_HALF_Q12) * k_alpha;
    assign z_full = 48'(HALF_SQRT3_Q12) * k_beta
        - 48'(THREE_HALF_Q12) * k_alpha;
    assign r2_full = 48'(SQRT3_Q12) * 48'(alpha_ff);

    // latch reference and scaled time terms at the period tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref1_ff <= '0;
            ref2_ff <= '0;
            ref3_ff <= '0;
            x_ff <= '0;
            y_ff <= '0;
            z_ff <= '0;
        end else if (state_ff == ST_IDLE && period_tick && enable_ff) begin
            ref1_ff <= 17'(beta_ff);
            ref2_ff <= 17'((r2_full >>> FRAC_W) - 48'(beta_ff)) >>> 1;
            ref3_ff <= 17'((-(r2_full >>> FRAC_W)) - 48'(beta_ff)) >>> 1;
            x_ff <= TIME_W'(x_full >>> PROD_SHIFT);
            y_ff <= TIME_W'(y_full >>> PROD_SHIFT);
            z_ff <= TIME_W'(z_full >>> PROD_SHIFT);
        end
    end

    assign sector = {ref3_ff > 0, ref2_ff > 0, ref1_ff > 0};

    always_comb begin
        t1_raw = '0;
        t2_raw = '0;
        unique case (sector)
            3'h1: begin
                t1_raw = z_ff;
                t2_raw = y_ff;
            end
            3'h2: begin
                t1_raw = y_ff;
                t2_raw = -x_ff;
            end
            3'h3: begin
                t1_raw = -z_ff;
                t2_raw = x_ff;
            end
            3'h4: begin
                t1_raw = -x_ff;
                t2_raw = z_ff;
            end
            3'h5: begin
                t1_raw = x_ff;
                t2_raw = -y_ff;
            end
            3'h6: begin
                t1_raw = -y_ff;
                t2_raw = -z_ff;
            end
            3'h0, 3'h7: begin
                t1_raw = '0;
                t2_raw = '0;
            end
        endcase
    end

    // rounding can leave a tiny negative time; clamp it to zero
    assign t1_pos = t1_raw[TIME_W-1] ? '0 : TIME_W'(t1_raw);
    assign t2_pos = t2_raw[TIME_W-1] ? '0 : TIME_W'(t2_raw);
    assign t_sum = t1_pos + t2_pos;

    assign den = DIV_W'(t_sum);
    assign num1 = DIV_W'(t1_pos) * DIV_W'(PWM_PERIOD_COUNT);
    assign num2 = DIV_W'(t2_pos) * DIV_W'(PWM_PERIOD_COUNT);
    assign div_start = (state_ff == ST_SELECT)
        && (t_sum > TIME_W'(PWM_PERIOD_COUNT));

    svm_divider #(.W(DIV_W)) u_div_t1 (
        .clock(clock),
        .rst_n(rst_n),
        .start(div_start),
        .num(num1),
        .den(den),
        .done(div_done),
        .quot(q1)
    );

    svm_divider #(.W(DIV_W)) u_div_t2 (
        .clock(clock),
        .rst_n(rst_n),
        .start(div_start),
        .num(num2),
        .den(den),
        .done(),
        .quot(q2)
    );

    // sequencing, one pass per period tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (period_tick && enable_ff) begin
                        state_ff <= ST_SELECT;
                    end
                end
                ST_SELECT: begin
                    state_ff <= div_start ? ST_DIVIDE : ST_ONTIME;
                end
                ST_DIVIDE: begin
                    if (div_done) begin
                        state_ff <= ST_ONTIME;
                    end
                end
                ST_ONTIME: state_ff <= ST_LOAD;
                ST_LOAD: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // hold times, replaced by scaled ones on saturation
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t1_ff <= '0;
            t2_ff <= '0;
            sector_ff <= '0;
            sat_ff <= 1'b0;
        end else if (state_ff == ST_SELECT) begin
            t1_ff <= t1_pos;
            t2_ff <= t2_pos;
            sector_ff <= sector;
            sat_ff <= div_start;
        end else if (state_ff == ST_DIVIDE && div_done) begin
            t1_ff <= TIME_W'(q1);
            t2_ff <= TIME_W'(q2);
        end
    end

    // on times from the final boundary times
    assign t_rest = TIME_W'(PWM_PERIOD_COUNT) - t1_ff - t2_ff;
    assign ta = t_rest >> 1;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            on_ff <= '0;
        end else if (state_ff == ST_ONTIME) begin
            on_ff.first <= CMP_W'(ta);
            on_ff.second <= CMP_W'(ta + t1_ff);
            on_ff.third <= CMP_W'(ta + t1_ff + t2_ff);
        end
    end

    // sector routing of on times onto the phases
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_ff <= {HALF_PERIOD, HALF_PERIOD, HALF_PERIOD};
        end else if (state_ff == ST_LOAD) begin
            unique case (sector_ff)
                3'h1: compare_ff <= {on_ff.second, on_ff.first, on_ff.third};
                3'h2: compare_ff <= {on_ff.first, on_ff.third, on_ff.second};
                3'h3: compare_ff <= {on_ff.first, on_ff.second, on_ff.third};
                3'h4: compare_ff <= {on_ff.third, on_ff.second, on_ff.first};
                3'h5: compare_ff <= {on_ff.third, on_ff.first, on_ff.second};
                3'h6: compare_ff <= {on_ff.second, on_ff.third, on_ff.first};
                3'h0, 3'h7: begin
                    compare_ff <= {HALF_PERIOD, HALF_PERIOD, HALF_PERIOD};
                end
            endcase
        end
    end

    // single load strobe for all three phases
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_load_ff <= 1'b0;
        end else begin
            compare_load_ff <= (state_ff == ST_LOAD);
        end
    end

    assign compare_out = compare_ff;
    assign compare_load = compare_load_ff;

    // axi write: address and data taken independently
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                case (awaddr_ff)
                    REG_CTRL, REG_ALPHA, REG_BETA: s_axi_bresp <= RESP_OKAY;
                    REG_STATUS, REG_CMP12, REG_CMP3: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software written control and references, byte strobed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= 1'b0;
            alpha_ff <= '0;
            beta_ff <= '0;
        end else if (do_write) begin
            if (awaddr_ff == REG_CTRL && wstrb_ff[0]) begin
                enable_ff <= wdata_ff[CTRL_EN_BIT];
            end
            if (awaddr_ff == REG_ALPHA) begin
                if (wstrb_ff[0]) alpha_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) alpha_ff[15:8] <= wdata_ff[15:8];
            end
            if (awaddr_ff == REG_BETA) begin
                if (wstrb_ff[0]) beta_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) beta_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // read decode
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            REG_CTRL: begin
                rd_word[CTRL_EN_BIT] = enable_ff;
                rd_word[CMP_HI_LSB +: REF_W] = BUS_VOLTAGE_PU;
            end
            REG_ALPHA: rd_word = 32'(alpha_ff);
            REG_BETA: rd_word = 32'(beta_ff);
            REG_STATUS: begin
                rd_word[ST_SECTOR_LSB +: 3] = sector_ff;
                rd_word[ST_BUSY_BIT] = (state_ff != ST_IDLE);
                rd_word[ST_SAT_BIT] = sat_ff;
                rd_word[ST_ZERO_BIT] = (sector_ff == 3'h0)
                    || (sector_ff == 3'h7);
            end
            REG_CMP12: begin
                rd_word[CMP_W-1:0] = compare_ff.phase_one_compare;
                rd_word[CMP_HI_LSB +: CMP_W] = compare_ff.phase_two_compare;
            end
            REG_CMP3: rd_word[CMP_W-1:0] = compare_ff.phase_three_compare;
            default: rd_ok = 1'b0;
        endcase
    end

    // axi read channel
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

//--- sim/svm_chk.sv
/* svm_chk: port checks on svm_top for compares and register bus.
 * assumes the pwm side ticks no faster than one pass takes. */
`timescale 1ns/1ns
module svm_chk (
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic period_tick, // period boundary pulse
    input wire svm_pkg::svm_compare_s compare_out, // phase compares
    input wire logic compare_load, // new compares strobe
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_wready, // write data ready
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    import svm_pkg::*;
    logic [15:0] c1, c2, c3, lo, hi;
    logic [16:0] span;
    logic [7:0] since_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // smallest plus largest compare of the set
    assign c1 = compare_out.phase_one_compare;
    assign c2 = compare_out.phase_two_compare;
    assign c3 = compare_out.phase_three_compare;
    assign lo = (c1 < c2) ? ((c1 < c3) ? c1 : c3) : ((c2 < c3) ? c2 : c3);
    assign hi = (c1 > c2) ? ((c1 > c3) ? c1 : c3) : ((c2 > c3) ? c2 : c3);
    assign span = {1'b0, lo} + {1'b0, hi};
    // cycles since the last period boundary
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) since_ff <= 8'hFF;
        else if (period_tick) since_ff <= 8'h00;
        else if (since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_LOAD_PULSE: assert property (compare_load |=> !compare_load)
        else $error("compare load longer than one cycle");
    AST_CMP_HOLD: assert property (!compare_load |-> $stable(compare_out))
        else $error("compares moved without load");
    AST_CMP_SPAN: assert property (compare_load |-> hi <= 16'h03E8 &&
        (span == 17'h003E8 || span == 17'h003E7))
        else $error("on times do not fill the period");
    AST_LOAD_TIME: assert property (compare_load |->
        since_ff >= 8'h03 && since_ff <= 8'h28)
        else $error("load not tied to a period tick");
    AST_B_ANSWER: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_ANSWER: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read data missing");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule

//--- sim/svm_pwm_model.sv
/* svm_pwm_model: pwm unit, makes period ticks, takes compares on load.
 * assumes one clock shared with the modulator. */
`timescale 1ns/1ns
module svm_pwm_model #(
    parameter int PER = 64
) (
    input wire logic clock, // system clock
    input wire logic rst_n, // async reset, active low
    output logic period_tick, // period boundary pulse
    input wire svm_pkg::svm_compare_s compare_out, // new compares
    input wire logic compare_load, // compares valid strobe
    output svm_pkg::svm_compare_s held // compares in use
);
    import svm_pkg::*;
    logic [7:0] cnt_ff;
    // period counter, one tick per period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            period_tick <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == 8'(PER - 1)) ? 8'h00 : cnt_ff + 8'h01;
            period_tick <= (cnt_ff == 8'(PER - 1));
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) held <= {3{HALF_PERIOD}};
        else if (compare_load) held <= compare_out;
    end
endmodule

//--- sim/tb.sv
/* tb: register bus tests of svm_top with a pwm unit model.
 * assumes the checker svm_chk is compiled alongside. */
`timescale 1ns/1ns
module tb;
    import svm_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, period_tick, compare_load;
    svm_compare_s compare_out, held, e;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic signed [15:0] va[8] = '{16'sh0377, 16'sh0000, 16'shFC89,
        16'shFC89, 16'sh0000, 16'sh0377, 16'sh0000, 16'sh2000};
    logic signed [15:0] vb[8] = '{16'sh0200, 16'sh0400, 16'sh0200,
        16'shFE00, 16'shFC00, 16'shFE00, 16'sh0000, 16'sh0100};
    int p1[6] = '{2, 1, 1, 3, 3, 2}, p2[6] = '{1, 3, 2, 2, 1, 3};
    int p3[6] = '{3, 2, 3, 1, 2, 1}, q1[6] = '{2, 1, 5, 3, 0, 4};
    int q2[6] = '{1, 3, 0, 2, 4, 5}, n_fail = 0, checks = 0, cyc = 0, s;
    svm_top i_svm_top (.clock, .rst_n, .period_tick, .compare_out,
        .compare_load, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    svm_pwm_model i_svm_pwm_model (.clock, .rst_n, .period_tick,
        .compare_out, .compare_load, .held);
    // expected compares worked out from the references
    function automatic svm_compare_s exp_cmp(input longint a, b,
        output int s);
        longint k, pp, t1, t2, v[6], t[1:3];
        k = BUS_INVERSE_SCALE;
        pp = PWM_PERIOD_COUNT;
        v[0] = (SQRT3_Q12 * k * b) >>> PROD_SHIFT;
        v[1] = (HALF_SQRT3_Q12 * k * b + THREE_HALF_Q12 * k * a)
            >>> PROD_SHIFT;
        v[2] = (HALF_SQRT3_Q12 * k * b - THREE_HALF_Q12 * k * a)
            >>> PROD_SHIFT;
        for (int i = 0; i < 3; i++) v[i + 3] = -v[i];
        s = (b > 0) + 2 * (SQRT3_Q12 * a > (b <<< FRAC_W))
            + 4 * (-SQRT3_Q12 * a > (b <<< FRAC_W));
        if (s == 0 || s == 7) return {3{HALF_PERIOD}};
        t1 = (v[q1[s - 1]] < 0) ? 0 : v[q1[s - 1]];
        t2 = (v[q2[s - 1]] < 0) ? 0 : v[q2[s - 1]];
        k = t1 + t2;
        if (k > pp) begin
            t1 = t1 * pp / k;
            t2 = t2 * pp / k;
        end
        t[1] = (pp - t1 - t2) >>> 1;
        t[2] = t[1] + t1;
        t[3] = t[2] + t2;
        return {16'(t[p1[s - 1]]), 16'(t[p2[s - 1]]), 16'(t[p3[s - 1]])};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] w);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wait_load();
        do @(posedge clock); while (compare_load !== 1'b1);
    endtask
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // free running clock and hang guard
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            print_verdict();
        end
    end
    // main sequence of bus calls
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        chk(compare_out, {3{HALF_PERIOD}});
        axi_rd(8'h18);
        chk({d, 14'h0, r}, {32'h0, 14'h0, RESP_SLVERR});
        axi_wr(REG_CMP3, 32'h0000_1234);
        axi_rd(REG_CMP3);
        chk(48'(d[15:0]), 48'(HALF_PERIOD));
        axi_wr(REG_CTRL, 32'h0000_0001);
        axi_rd(REG_CTRL);
        chk(48'(d), 48'({BUS_VOLTAGE_PU, 16'h0001}));
        for (int i = 0; i < 8; i++) begin
            axi_wr(REG_ALPHA, {16'h0000, va[i]});
            axi_wr(REG_BETA, {16'h0000, vb[i]});
            wait_load();
            wait_load();
            e = exp_cmp(va[i], vb[i], s);
            chk(compare_out, e);
            axi_rd(REG_STATUS);
            chk(48'(d[2:0]), 48'(s));
            chk(held, e);
            axi_rd(REG_CMP12);
            chk(48'(d), 48'({e[31:16], e[47:32]}));
        end
        print_verdict();
    end
endmodule
bind svm_top svm_chk i_svm_chk (.clock, .rst_n, .period_tick, .compare_out,
    .compare_load, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
